// ==== verilog/pcivf_pkg.sv ====
// pcivf_pkg: constants, field layouts and types of the reset and clock controller
`default_nettype none
package pcivf_pkg;

  // ------------------------------------------------------------
  // clocking and timing
  // ------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ   = 200;
  localparam int unsigned RX_SD_TIME_MS = 3;
  localparam int unsigned RX_SD_CYC     = RX_SD_TIME_MS * SYS_CLK_MHZ * 1000;
  localparam int unsigned RX_CNT_W      = 20;
  localparam int unsigned TX_LOCK_CYC   = 127;
  localparam int unsigned TX_CNT_W      = 7;

  // ------------------------------------------------------------
  // virtual functions
  // ------------------------------------------------------------
  localparam int unsigned VF_NUM   = 4;
  localparam int unsigned VF_IDX_W = 2;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam int unsigned    CFG_ADDR_W    = 12;
  localparam logic [11:0]    OFS_CAP_LIST  = 12'h080;
  localparam logic [11:0]    OFS_DEV_CTLST = 12'h088;

  // ------------------------------------------------------------
  // capability list fields
  // ------------------------------------------------------------
  localparam logic [7:0]  CAP_ID_VAL   = 8'h10;
  localparam logic [7:0]  CAP_NEXT_VAL = 8'h00;
  localparam int unsigned CAP_ID_LSB   = 0;
  localparam int unsigned CAP_NEXT_LSB = 8;
  localparam int unsigned CAP_VER_LSB  = 16;
  localparam logic [2:0]  CAP_VER_RST  = 3'h2;

  // ------------------------------------------------------------
  // device control / status fields
  // ------------------------------------------------------------
  localparam int unsigned DCS_FLR_BIT  = 15;
  localparam int unsigned DCS_ERR_LSB  = 16;
  localparam int unsigned DCS_TP_BIT   = 21;
  localparam logic [3:0]  ERR_RST      = 4'h0;

  // ------------------------------------------------------------
  // pipe receiver detect code
  // ------------------------------------------------------------
  localparam logic [2:0]  RXSTAT_DET_DONE = 3'h3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LT_DETECT_QUIET,
    LT_DETECT_ACTIVE,
    LT_POLLING_ACTIVE
  } pcivf_ltssm_t;

  typedef enum logic [1:0] {
    CLK_62M5,
    CLK_125M,
    CLK_250M
  } pcivf_clk_sel_t;

  // pins from outside the clock domain
  typedef struct packed {
    logic       perst_n;
    logic       npor;
    logic       rx_pll_locked;
    logic       rx_sig_det;
    logic       tx_pll_locked;
    logic       phystatus;
    logic [2:0] rxstatus;
  } pcivf_pins_t;

  // configuration access from the bridge
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [VF_IDX_W-1:0]   vf;
    logic [11:0]           addr;
    logic [31:0]           wdata;
  } pcivf_cfg_req_t;

  typedef struct packed {
    logic                  rvalid;
    logic [31:0]           rdata;
  } pcivf_cfg_rsp_t;

  // static link configuration
  typedef struct packed {
    logic [3:0] lanes;
    logic [1:0] gen;
    logic       if_256;
  } pcivf_link_cfg_t;

  localparam logic [RX_CNT_W-1:0] RX_CNT_RST = 20'h00000;
  localparam logic [TX_CNT_W-1:0] TX_CNT_RST = 7'h00;

endpackage

`default_nettype wire

// ==== verilog/pcivf_sync.sv ====
// pcivf_sync: two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none

module pcivf_sync (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire pcivf_pkg::pcivf_pins_t i_async,
  output var  pcivf_pkg::pcivf_pins_t o_sync
);
  import pcivf_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pcivf_pins_t meta;
    pcivf_pins_t stable;
  } pcivf_sync_st_t;

  pcivf_sync_st_t s_r;
  pcivf_sync_st_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = i_async;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r.stable;

endmodule

`default_nettype wire

// ==== verilog/pcivf_reset_clock_ctrl.sv ====
// pcivf_reset_clock_ctrl: reset sequencing, function-level reset and vf config registers
//
// Behaviour
// (R1) capability list bits 7:0 return fixed express capability id, not writable
// (R2) capability list bits 15:8 read null next pointer
// (R3) bits 18:16 hold capability version; bits 31:19 read-only zero
// (R4) writing one to control bit 15 starts vf reset if pf capable; reads zero
// (R5) status bit 21 set while vf has outstanding non-posted requests
// (R6) error bits 16..19 set on events, cleared by writing one
// (R7) core reset indication released once platform reset or power-on reset released
// (R8) receive clock lock moves training from detect quiet to detect active
// (R9) phystatus pulse with rxstatus three moves detect active to polling active
// (R10) receive logic reset released after signal detect stable three milliseconds
// (R11) transmit transceiver active-low reset released after power-on reset released
// (R12) transmit logic reset released after transmit lock stable 127 cycles
// (R13) host halts traffic before function reset and re-enumerates afterwards
// (R14) function reset restores writable non-sticky bits and raises reset-active
// (R15) application clears function state then raises reset-done
// (R16) reset-done from application drops reset-active of that function
// (R17) core clock frequency picked from width, rate and interface width
// (R18) clock choice kept after link trains down
// (R19) user clock never slower than core output clock
// (R20) integrator supplies reference clock straight to transceiver
// (R21) pin-side signals are synchronised before the core logic reads them
`timescale 1ns/1ps
`default_nettype none

module pcivf_reset_clock_ctrl #(
  parameter int unsigned P_RX_SD_CYC = pcivf_pkg::RX_SD_CYC
) (
  input  wire logic                                 i_sys_clk,
  input  wire logic                                 i_rst,
  input  wire pcivf_pkg::pcivf_pins_t               i_pins,
  input  wire pcivf_pkg::pcivf_link_cfg_t           i_link_cfg,
  input  wire logic                                 i_pf_flr_capable,
  input  wire logic [pcivf_pkg::VF_NUM-1:0]         i_np_pending,
  input  wire logic [pcivf_pkg::VF_NUM-1:0][3:0]    i_err_evt,
  input  wire logic [pcivf_pkg::VF_NUM-1:0]         i_flr_done,
  input  wire pcivf_pkg::pcivf_cfg_req_t            i_cfg_req,
  output var  pcivf_pkg::pcivf_cfg_rsp_t            o_cfg_rsp,
  output var  logic [pcivf_pkg::VF_NUM-1:0]         o_flr_active,
  output var  logic                                 o_reset_status,
  output var  logic                                 o_serdes_rst_n,
  output var  logic                                 o_rx_logic_rst,
  output var  logic                                 o_tx_logic_rst,
  output var  pcivf_pkg::pcivf_ltssm_t              o_ltssm,
  output var  pcivf_pkg::pcivf_clk_sel_t            o_clk_sel
);
  import pcivf_pkg::*;

  // ------------------------------------------------------------
  // derived constants
  // ------------------------------------------------------------
  localparam logic [RX_CNT_W-1:0] RX_CNT_END = RX_CNT_W'(P_RX_SD_CYC - 1);
  localparam logic [TX_CNT_W-1:0] TX_CNT_END = TX_CNT_W'(TX_LOCK_CYC - 1);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic hit_cap(input logic [11:0] a);
    hit_cap = (a == OFS_CAP_LIST);
  endfunction

  function automatic logic hit_dcs(input logic [11:0] a);
    hit_dcs = (a == OFS_DEV_CTLST);
  endfunction

  function automatic pcivf_clk_sel_t pick_clk(input pcivf_link_cfg_t c);
    pick_clk = CLK_62M5;
    case ({c.lanes, c.gen, c.if_256})
      {4'h8, 2'h1, 1'b0}: pick_clk = CLK_125M;
      {4'h4, 2'h2, 1'b0}: pick_clk = CLK_125M;
      {4'h8, 2'h2, 1'b0}: pick_clk = CLK_250M;
      {4'h8, 2'h2, 1'b1}: pick_clk = CLK_125M;
      {4'h2, 2'h3, 1'b0}: pick_clk = CLK_125M;
      {4'h4, 2'h3, 1'b0}: pick_clk = CLK_250M;
      {4'h4, 2'h3, 1'b1}: pick_clk = CLK_125M;
      {4'h8, 2'h3, 1'b1}: pick_clk = CLK_250M;
      default:            pick_clk = CLK_62M5;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  pcivf_pins_t pins_s;

  pcivf_sync u_sync ( // R21
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_pins),
    .o_sync    (pins_s)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pcivf_ltssm_t                 ltssm;
    logic                         phy_q;
    logic                         sd_q;
    logic                         lock_q;
    logic [RX_CNT_W-1:0]          rx_cnt;
    logic [TX_CNT_W-1:0]          tx_cnt;
    logic                         rx_rst;
    logic                         tx_rst;
    logic                         serdes_rst_n;
    logic                         reset_status;
    logic                         clk_held;
    pcivf_clk_sel_t               clk_sel;
    logic [VF_NUM-1:0][2:0]       ver;
    logic [VF_NUM-1:0][3:0]       err;
    logic [VF_NUM-1:0]            flr_act;
    pcivf_cfg_rsp_t               rsp;
  } pcivf_st_t;

  pcivf_st_t s_r;
  pcivf_st_t s_nxt;

  logic [31:0] cap_word;
  logic [31:0] dcs_word;

  always_comb begin
    s_nxt    = s_r;
    cap_word = 32'h0000_0000;
    dcs_word = 32'h0000_0000;

    // ----------------------------------------------------------
    // hard reset controller
    // ----------------------------------------------------------
    s_nxt.reset_status = !(pins_s.perst_n || pins_s.npor); // R7
    s_nxt.serdes_rst_n = pins_s.npor; // R11

    // ----------------------------------------------------------
    // core clock choice, taken once and held
    // ----------------------------------------------------------
    if (!s_r.clk_held) begin
      s_nxt.clk_sel  = pick_clk(i_link_cfg); // R17
      s_nxt.clk_held = 1'b1; // R18
    end

    // ----------------------------------------------------------
    // link training detect states
    // ----------------------------------------------------------
    s_nxt.phy_q = pins_s.phystatus;
    case (s_r.ltssm)
      LT_DETECT_QUIET: begin
        if (pins_s.rx_pll_locked) begin
          s_nxt.ltssm = LT_DETECT_ACTIVE; // R8
        end
      end
      LT_DETECT_ACTIVE: begin
        if (pins_s.phystatus && !s_r.phy_q && (pins_s.rxstatus == RXSTAT_DET_DONE)) begin
          s_nxt.ltssm = LT_POLLING_ACTIVE; // R9
        end
      end
      LT_POLLING_ACTIVE: begin
        if (!pins_s.rx_pll_locked) begin
          s_nxt.ltssm = LT_DETECT_QUIET;
        end
      end
      default: begin
        s_nxt.ltssm = LT_DETECT_QUIET;
      end
    endcase
    if (s_r.reset_status) begin
      s_nxt.ltssm = LT_DETECT_QUIET;
    end

    // ----------------------------------------------------------
    // receive logic reset
    // ----------------------------------------------------------
    s_nxt.sd_q = pins_s.rx_sig_det;
    if (!pins_s.rx_sig_det || (pins_s.rx_sig_det != s_r.sd_q)) begin
      s_nxt.rx_cnt = RX_CNT_RST;
      s_nxt.rx_rst = 1'b1; // R10
    end else if (s_r.rx_rst) begin
      if (s_r.rx_cnt == RX_CNT_END) begin
        s_nxt.rx_rst = 1'b0; // R10
      end else begin
        s_nxt.rx_cnt = s_r.rx_cnt + 1'b1;
      end
    end

    // ----------------------------------------------------------
    // transmit logic reset
    // ----------------------------------------------------------
    s_nxt.lock_q = pins_s.tx_pll_locked;
    if (!pins_s.tx_pll_locked || !s_r.serdes_rst_n ||
        (pins_s.tx_pll_locked != s_r.lock_q)) begin
      s_nxt.tx_cnt = TX_CNT_RST;
      s_nxt.tx_rst = 1'b1; // R12
    end else if (s_r.tx_rst) begin
      if (s_r.tx_cnt == TX_CNT_END) begin
        s_nxt.tx_rst = 1'b0; // R12
      end else begin
        s_nxt.tx_cnt = s_r.tx_cnt + 1'b1;
      end
    end

    // ----------------------------------------------------------
    // per-vf registers and function-level reset
    // ----------------------------------------------------------
    for (int v = 0; v < VF_NUM; v++) begin
      if (s_r.flr_act[v] && i_flr_done[v]) begin
        s_nxt.flr_act[v] = 1'b0; // R16
      end
      if (i_cfg_req.wr && (i_cfg_req.vf == VF_IDX_W'(v))) begin
        if (hit_cap(i_cfg_req.addr)) begin
          s_nxt.ver[v] = i_cfg_req.wdata[CAP_VER_LSB +: 3]; // R3
        end
        if (hit_dcs(i_cfg_req.addr)) begin
          s_nxt.err[v] = s_r.err[v] & ~i_cfg_req.wdata[DCS_ERR_LSB +: 4]; // R6
          if (i_cfg_req.wdata[DCS_FLR_BIT] && i_pf_flr_capable) begin
            s_nxt.flr_act[v] = 1'b1; // R4 R14
            s_nxt.ver[v]     = CAP_VER_RST; // R14
          end
        end
      end
      s_nxt.err[v] = s_nxt.err[v] | i_err_evt[v]; // R6
    end

    // ----------------------------------------------------------
    // configuration read
    // ----------------------------------------------------------
    cap_word[CAP_ID_LSB +: 8]   = CAP_ID_VAL; // R1
    cap_word[CAP_NEXT_LSB +: 8] = CAP_NEXT_VAL; // R2
    cap_word[CAP_VER_LSB +: 3]  = s_r.ver[i_cfg_req.vf]; // R3
    dcs_word[DCS_ERR_LSB +: 4]  = s_r.err[i_cfg_req.vf]; // R6
    dcs_word[DCS_TP_BIT]        = i_np_pending[i_cfg_req.vf]; // R5
    dcs_word[DCS_FLR_BIT]       = 1'b0; // R4

    s_nxt.rsp.rvalid = i_cfg_req.rd;
    if (i_cfg_req.rd) begin
      if (hit_cap(i_cfg_req.addr)) begin
        s_nxt.rsp.rdata = cap_word;
      end else if (hit_dcs(i_cfg_req.addr)) begin
        s_nxt.rsp.rdata = dcs_word;
      end else begin
        s_nxt.rsp.rdata = 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_r              <= '0;
      s_r.ltssm        <= LT_DETECT_QUIET;
      s_r.rx_cnt       <= RX_CNT_RST;
      s_r.tx_cnt       <= TX_CNT_RST;
      s_r.rx_rst       <= 1'b1;
      s_r.tx_rst       <= 1'b1;
      s_r.serdes_rst_n <= 1'b0;
      s_r.reset_status <= 1'b1;
      s_r.clk_sel      <= CLK_62M5;
      s_r.ver          <= {VF_NUM{CAP_VER_RST}};
      s_r.err          <= {VF_NUM{ERR_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_cfg_rsp      = s_r.rsp;
  assign o_flr_active   = s_r.flr_act;
  assign o_reset_status = s_r.reset_status;
  assign o_serdes_rst_n = s_r.serdes_rst_n;
  assign o_rx_logic_rst = s_r.rx_rst;
  assign o_tx_logic_rst = s_r.tx_rst;
  assign o_ltssm        = s_r.ltssm;
  assign o_clk_sel      = s_r.clk_sel;

endmodule

`default_nettype wire

// ==== testbench/pcivf_app_model.sv ====
// pcivf_app_model: application side answering function resets
`timescale 1ns/1ps
`default_nettype none
module pcivf_app_model (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_slow,
  input  wire logic [pcivf_pkg::VF_NUM-1:0] i_flr_active,
  output var  logic [pcivf_pkg::VF_NUM-1:0] o_flr_done
);
  import pcivf_pkg::*;
  int unsigned wait_r [VF_NUM];
  // ------------------------------------------------------------
  // clean-up then report done
  // ------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    for (int k = 0; k < VF_NUM; k++) begin
      if (!i_flr_active[k]) begin
        wait_r[k] <= 0;
        o_flr_done[k] <= 1'b0;
      end else if (wait_r[k] >= (i_slow ? 12 : 1)) begin
        o_flr_done[k] <= 1'b1;
      end else begin
        wait_r[k] <= wait_r[k] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pcivf_reset_clock_ctrl_properties.sv ====
// pcivf_rcc_props: port assertions of the reset and clock controller
`timescale 1ns/1ps
`default_nettype none
module pcivf_rcc_props #(
  parameter int unsigned P_RX_SD_CYC = 20
) (
  input wire logic                         i_sys_clk,
  input wire logic                         i_rst,
  input wire pcivf_pkg::pcivf_pins_t       i_pins,
  input wire logic                         i_pf_flr_capable,
  input wire logic [pcivf_pkg::VF_NUM-1:0] i_np_pending,
  input wire logic [pcivf_pkg::VF_NUM-1:0] i_flr_done,
  input wire pcivf_pkg::pcivf_cfg_req_t    i_cfg_req,
  input wire pcivf_pkg::pcivf_cfg_rsp_t    o_cfg_rsp,
  input wire logic [pcivf_pkg::VF_NUM-1:0] o_flr_active,
  input wire logic                         o_reset_status,
  input wire logic                         o_serdes_rst_n,
  input wire logic                         o_rx_logic_rst,
  input wire logic                         o_tx_logic_rst,
  input wire pcivf_pkg::pcivf_ltssm_t      o_ltssm,
  input wire pcivf_pkg::pcivf_clk_sel_t    o_clk_sel
);
  import pcivf_pkg::*;
  logic [VF_IDX_W-1:0] vf_r;
  logic                tp_r;
  logic [VF_NUM-1:0]   done_r;
  logic [19:0]         rx_cnt_r;
  logic [7:0]          tx_cnt_r;
  logic                rd_cap;
  logic                rd_dcs;
  logic                flr_wr;
  assign rd_cap = i_cfg_req.rd && i_cfg_req.addr == OFS_CAP_LIST;
  assign rd_dcs = i_cfg_req.rd && i_cfg_req.addr == OFS_DEV_CTLST;
  assign flr_wr = i_cfg_req.wr && i_cfg_req.addr == OFS_DEV_CTLST && i_cfg_req.wdata[15];
  always_ff @(posedge i_sys_clk) begin
    vf_r     <= i_cfg_req.vf;
    tp_r     <= i_np_pending[i_cfg_req.vf];
    done_r   <= o_flr_active & i_flr_done;
    rx_cnt_r <= (i_rst || !i_pins.rx_sig_det) ? '0 : rx_cnt_r + {19'h0, ~&rx_cnt_r};
    tx_cnt_r <= (i_rst || !(i_pins.tx_pll_locked && i_pins.npor)) ? '0 : tx_cnt_r + {7'h0, ~&tx_cnt_r};
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_to_poll; $past(o_ltssm) != LT_POLLING_ACTIVE ##0 o_ltssm == LT_POLLING_ACTIVE; endsequence
  property p_cap_id; rd_cap |=> o_cfg_rsp.rvalid && o_cfg_rsp.rdata[7:0] == CAP_ID_VAL; endproperty
  property p_cap_nxt; rd_cap |=> o_cfg_rsp.rdata[15:8] == CAP_NEXT_VAL; endproperty
  property p_cap_hi; rd_cap |=> o_cfg_rsp.rdata[31:19] == 13'h0; endproperty
  property p_flr_rd; rd_dcs |=> o_cfg_rsp.rdata[15] == 1'b0; endproperty
  property p_tp; rd_dcs |=> o_cfg_rsp.rdata[21] == tp_r; endproperty
  property p_flr_go; flr_wr && i_pf_flr_capable |=> o_flr_active[vf_r]; endproperty
  property p_flr_end; (o_flr_active & i_flr_done) != '0 && !i_cfg_req.wr |=> (o_flr_active & done_r) == '0; endproperty
  property p_rst_st; (i_pins.perst_n || i_pins.npor)[*4] |-> !o_reset_status; endproperty
  property p_serdes; i_pins.npor[*4] |-> o_serdes_rst_n; endproperty
  property p_rx_min; $fell(o_rx_logic_rst) |-> rx_cnt_r >= P_RX_SD_CYC; endproperty
  property p_rx_max; rx_cnt_r == P_RX_SD_CYC + 8 |-> !o_rx_logic_rst; endproperty
  property p_tx_min; $fell(o_tx_logic_rst) |-> tx_cnt_r >= 8'd127; endproperty
  property p_tx_max; tx_cnt_r == 8'd140 |-> !o_tx_logic_rst; endproperty
  property p_lt_act; (i_pins.rx_pll_locked && i_pins.npor)[*7] |-> o_ltssm != LT_DETECT_QUIET; endproperty
  property p_lt_poll; s_to_poll |-> $past(o_ltssm) == LT_DETECT_ACTIVE; endproperty
  property p_clk_hold; !$past(i_rst) && !$past(i_rst, 2) |-> $stable(o_clk_sel); endproperty
  a_cap_id: assert property (p_cap_id) else $error("capability id wrong");
  a_cap_nxt: assert property (p_cap_nxt) else $error("next pointer not null");
  a_cap_hi: assert property (p_cap_hi) else $error("upper capability bits set");
  a_flr_rd: assert property (p_flr_rd) else $error("reset bit read as one");
  a_tp: assert property (p_tp) else $error("pending bit wrong");
  a_flr_go: assert property (p_flr_go) else $error("reset-active not raised");
  a_flr_end: assert property (p_flr_end) else $error("reset-active not dropped");
  a_rst_st: assert property (p_rst_st) else $error("core reset held");
  a_serdes: assert property (p_serdes) else $error("transceiver reset held");
  a_rx_min: assert property (p_rx_min) else $error("rx reset released early");
  a_rx_max: assert property (p_rx_max) else $error("rx reset released late");
  a_tx_min: assert property (p_tx_min) else $error("tx reset released early");
  a_tx_max: assert property (p_tx_max) else $error("tx reset released late");
  a_lt_act: assert property (p_lt_act) else $error("training stuck in quiet");
  a_lt_poll: assert property (p_lt_poll) else $error("polling not from active");
  a_clk_hold: assert property (p_clk_hold) else $error("clock choice changed");
endmodule
bind pcivf_reset_clock_ctrl pcivf_rcc_props #(.P_RX_SD_CYC(P_RX_SD_CYC)) i_pcivf_rcc_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pins(i_pins), .i_pf_flr_capable(i_pf_flr_capable),
  .i_np_pending(i_np_pending), .i_flr_done(i_flr_done), .i_cfg_req(i_cfg_req),
  .o_cfg_rsp(o_cfg_rsp), .o_flr_active(o_flr_active), .o_reset_status(o_reset_status),
  .o_serdes_rst_n(o_serdes_rst_n), .o_rx_logic_rst(o_rx_logic_rst),
  .o_tx_logic_rst(o_tx_logic_rst), .o_ltssm(o_ltssm), .o_clk_sel(o_clk_sel));
`default_nettype wire

// ==== testbench/test_pcivf_reset_clock_ctrl.sv ====
// test_pcivf_reset_clock_ctrl: self-checking bench of the reset and clock controller
`timescale 1ns/1ps
`default_nettype none
module test_pcivf_reset_clock_ctrl;
  import pcivf_pkg::*;
  localparam int unsigned P_SD = 20;
  logic                   i_sys_clk = 1'b0;
  logic                   i_rst = 1'b1;
  pcivf_pins_t            i_pins = '0;
  pcivf_link_cfg_t        i_link_cfg = '0;
  logic                   i_pf_flr_capable = 1'b0;
  logic                   slow = 1'b0;
  logic [VF_NUM-1:0]      i_np_pending = '0;
  logic [VF_NUM-1:0][3:0] i_err_evt = '0;
  logic [VF_NUM-1:0]      i_flr_done;
  pcivf_cfg_req_t         i_cfg_req = '0;
  pcivf_cfg_rsp_t         o_cfg_rsp;
  logic [VF_NUM-1:0]      o_flr_active;
  logic                   o_reset_status;
  logic                   o_serdes_rst_n;
  logic                   o_rx_logic_rst;
  logic                   o_tx_logic_rst;
  pcivf_ltssm_t           o_ltssm;
  pcivf_clk_sel_t         o_clk_sel;
  int                     fails = 0;
  int                     n_compared = 0;
  logic [31:0]            exp_q [$];
  logic [31:0]            w;
  // link setting table: lanes, rate, wide interface, clock choice
  logic [8:0] tbl [9] = '{9'h109, 9'h091, 9'h112, 9'h115, 9'h059, 9'h09a, 9'h09d, 9'h11e, 9'h028};
  always #2.5 i_sys_clk = ~i_sys_clk;
  pcivf_reset_clock_ctrl #(.P_RX_SD_CYC(P_SD)) i_pcivf_reset_clock_ctrl (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pins(i_pins), .i_link_cfg(i_link_cfg),
    .i_pf_flr_capable(i_pf_flr_capable), .i_np_pending(i_np_pending), .i_err_evt(i_err_evt),
    .i_flr_done(i_flr_done), .i_cfg_req(i_cfg_req), .o_cfg_rsp(o_cfg_rsp),
    .o_flr_active(o_flr_active), .o_reset_status(o_reset_status),
    .o_serdes_rst_n(o_serdes_rst_n), .o_rx_logic_rst(o_rx_logic_rst),
    .o_tx_logic_rst(o_tx_logic_rst), .o_ltssm(o_ltssm), .o_clk_sel(o_clk_sel));
  pcivf_app_model i_pcivf_app_model (.i_sys_clk(i_sys_clk), .i_slow(slow),
    .i_flr_active(o_flr_active), .o_flr_done(i_flr_done));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
  endtask
  task automatic cfg(input logic wr, input logic [1:0] vf, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_err_evt <= '0;
    i_cfg_req <= '{wr: wr, rd: !wr, vf: vf, addr: a, wdata: d};
    if (!wr) exp_q.push_back(e);
    @(posedge i_sys_clk);
    i_cfg_req <= '0;
  endtask
  task automatic phy(input logic [2:0] code);
    @(posedge i_sys_clk);
    i_pins.phystatus <= 1'b1;
    i_pins.rxstatus <= code;
    @(posedge i_sys_clk);
    i_pins.phystatus <= 1'b0;
    tick(5);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(negedge i_sys_clk) begin
    if (o_cfg_rsp.rvalid === 1'b1) begin
      check(o_cfg_rsp.rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_0bad);
    end
  end
  initial begin
    tick(5000);
    fails++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h874cb6f7));
    for (int k = 0; k < 9; k++) begin
      i_link_cfg <= tbl[k][8:2];
      do_reset();
      tick(2);
      check(o_clk_sel, tbl[k][1:0]);
    end
    i_link_cfg <= tbl[7][8:2];
    tick(3);
    check(o_clk_sel, CLK_62M5);
    check({o_reset_status, o_serdes_rst_n, o_ltssm}, 4'b1000);
    @(posedge i_sys_clk) i_pins.perst_n <= 1'b1;
    tick(4);
    check({o_reset_status, o_serdes_rst_n}, 2'b00);
    @(posedge i_sys_clk) i_pins.npor <= 1'b1;
    tick(4);
    check({o_reset_status, o_serdes_rst_n}, 2'b01);
    @(posedge i_sys_clk) i_pins <= '{perst_n: 1, npor: 1, rx_sig_det: 1, tx_pll_locked: 1, default: 0};
    tick(20);
    check(o_rx_logic_rst, 1'b1);
    tick(12);
    check(o_rx_logic_rst, 1'b0);
    @(posedge i_sys_clk) i_pins.rx_sig_det <= 1'b0;
    @(posedge i_sys_clk) i_pins.rx_sig_det <= 1'b1;
    tick(4);
    check({o_rx_logic_rst, o_tx_logic_rst, o_ltssm}, 4'b1100);
    tick(28);
    check(o_rx_logic_rst, 1'b0);
    tick(56);
    check(o_tx_logic_rst, 1'b1);
    tick(20);
    check(o_tx_logic_rst, 1'b0);
    @(posedge i_sys_clk) i_pins.rx_pll_locked <= 1'b1;
    tick(7);
    check(o_ltssm, LT_DETECT_ACTIVE);
    phy(3'h2);
    check(o_ltssm, LT_DETECT_ACTIVE);
    phy(RXSTAT_DET_DONE);
    check(o_ltssm, LT_POLLING_ACTIVE);
    for (int v = 0; v < VF_NUM; v++) begin
      w = $urandom();
      cfg(0, 2'(v), OFS_CAP_LIST, 0, 32'h0002_0010);
      cfg(1, 2'(v), OFS_CAP_LIST, w, 0);
      cfg(0, 2'(v), OFS_CAP_LIST, 0, {13'h0, w[18:16], 16'h0010});
      i_np_pending[v] <= w[0];
      i_err_evt[v] <= w[7:4];
      cfg(0, 2'(v), OFS_DEV_CTLST, 0, {10'h0, w[0], 1'b0, w[7:4], 16'h0});
      cfg(1, 2'(v), OFS_DEV_CTLST, {12'h0, w[11:8], 16'h0}, 0);
      cfg(0, 2'(v), OFS_DEV_CTLST, 0, {10'h0, w[0], 1'b0, w[7:4] & ~w[11:8], 16'h0});
    end
    cfg(1, 0, 12'h084, 32'hffff_ffff, 0);
    cfg(0, 0, 12'h084, 0, 0);
    i_np_pending <= '0;
    cfg(1, 2, OFS_CAP_LIST, 32'h0005_0000, 0);
    cfg(1, 2, OFS_DEV_CTLST, 32'h0000_8000, 0);
    tick(2);
    check(o_flr_active, 4'h0);
    i_pf_flr_capable <= 1'b1;
    slow <= 1'b1;
    cfg(1, 2, OFS_DEV_CTLST, 32'h0000_8000, 0);
    tick(1);
    check(o_flr_active, 4'h4);
    cfg(0, 2, OFS_CAP_LIST, 0, 32'h0002_0010);
    tick(1);
    check(o_flr_active, 4'h4);
    for (int i = 0; i < 40 && o_flr_active !== 4'h0; i++) tick(1);
    check(o_flr_active, 4'h0);
    slow <= 1'b0;
    cfg(1, 3, OFS_DEV_CTLST, 32'h0000_8000, 0);
    tick(1);
    check(o_flr_active, 4'h8);
    tick(5);
    check(o_flr_active, 4'h0);
    tick(3);
    print_verdict();
  end
endmodule
`default_nettype wire
